// >>> hw/hes_keeper.sv
// Weak bus-hold keeper that remembers the last valid driven level
`timescale 1ns/100ps
`default_nettype none
module hes_keeper
	import hes_pkg::*;
(
	input  wire logic clk,      // System clock
	input  wire logic reset,    // Async reset, active high
	input  wire logic ce,       // Clock enable
	input  wire logic drive_en, // Strong drive active
	input  wire logic drive_v,  // Level being driven
	output logic      keep_v    // Last valid level
);
	// Capture only while strongly driven, so a float holds the last level
	always_ff @(posedge clk or posedge reset) begin
		if (reset)
			keep_v <= RST_KEEP;
		else if (ce && drive_en)
			keep_v <= drive_v;
	end
endmodule : hes_keeper
`default_nettype wire

// >>> hw/hes_pin.sv
// Multiplexed high-half byte-enable and status-bit-seven pin driver
`timescale 1ns/100ps
`default_nettype none
module hes_pin
	import hes_pkg::*;
(
	input  wire logic       clk,              // System clock, 10 MHz
	input  wire logic       reset,            // Async reset, active high
	input  wire logic       ce,               // Clock enable, freezes state
	input  wire logic       cycle_start,      // Pulse: begin a bus cycle
	input  wire logic [1:0] cycle_kind,       // Read, write or acknowledge
	input  wire logic [1:0] cycle_size,       // Byte or word
	input  wire logic       addr_lsb,         // Address bit zero of cycle
	input  wire logic       inta_first,       // First acknowledge of a pair
	input  wire logic       wait_req,         // Insert a wait after T3
	input  wire logic       hold_ack,         // Local bus hold or grant
	input  wire logic       status_bit_seven, // Status value for T2..T4
	output logic            high_enable_status_pin_o,  // Pin output level
	output logic            high_enable_status_pin_oe, // Pin strong drive
	output logic            address_bit_zero,          // Address bit zero
	output logic            high_half_enable,          // Latched enable
	output logic [2:0]      bus_tstate                 // Current T-state
);
	tstate_t ts_ff;
	tstate_t nxt_ts;
	logic    kind_inta_ff;
	logic    hen_ff;
	logic    a0_ff;
	logic    pin_ff;
	logic    oe_ff;
	logic    keep_v;

	// Cycle qualifiers of the request
	wire is_inta   = (cycle_kind == 2'(XF_INTA));
	wire is_word   = (cycle_size == SIZE_WORD);
	wire upper_mv  = is_word || addr_lsb;
	wire req_hen_n = is_inta ? ~inta_first : ~upper_mv;
	wire req_a0    = is_word ? 1'b0 : addr_lsb;

	// T-state sequencer; wait states stretch T3
	always_comb begin
		nxt_ts = ts_ff;
		case (ts_ff)
			TS_IDLE: if (cycle_start) nxt_ts = TS_T1;
			TS_T1:   nxt_ts = TS_T2;
			TS_T2:   nxt_ts = TS_T3;
			TS_T3:   if (!wait_req) nxt_ts = TS_T4;
			TS_T4:   nxt_ts = cycle_start ? TS_T1 : TS_IDLE;
			default: nxt_ts = TS_IDLE;
		endcase
	end

	wire enter_t1 = (nxt_ts == TS_T1) && (ts_ff != TS_T1);
	// drive only outside hold and idle; in acknowledge only on entry to T1
	wire drive_ok = !hold_ack && !(kind_inta_ff && !enter_t1)
		&& (nxt_ts != TS_IDLE);
	wire pin_val  = (nxt_ts == TS_T1) ? req_hen_n : status_bit_seven;
	wire hen_val  = enter_t1 ? req_hen_n : hen_ff;

	always_ff @(posedge clk or posedge reset) begin
		if (reset)
			ts_ff <= TS_IDLE;
		else if (ce)
			ts_ff <= nxt_ts;
	end

	// Latch cycle attributes at the start of T1
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			kind_inta_ff <= 1'b0;
			a0_ff        <= 1'b0;
		end else if (ce && enter_t1) begin
			kind_inta_ff <= is_inta;
			a0_ff        <= req_a0;
		end
	end

	// Pin flip-flops; T1 of every acknowledge outside hold still drives the enable, low for the first
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			hen_ff <= RST_PIN_OUT;
			pin_ff <= RST_PIN_OUT;
			oe_ff  <= RST_PIN_OE;
		end else if (ce) begin
			hen_ff <= hen_val;
			oe_ff  <= drive_ok || (enter_t1 && is_inta && !hold_ack);
			// keep last level
			// The keeper lags the pin by one edge, so use the pin itself then
			pin_ff <= (drive_ok || (enter_t1 && is_inta && !hold_ack))
				? pin_val : (oe_ff ? pin_ff : keep_v);
		end
	end

	// Keeper follows the pin while driven
	hes_keeper u_keeper (
		.clk      (clk),
		.reset    (reset),
		.ce       (ce),
		.drive_en (oe_ff),
		.drive_v  (pin_ff),
		.keep_v   (keep_v)
	);

	assign high_enable_status_pin_o  = pin_ff;
	assign high_enable_status_pin_oe = oe_ff;
	assign high_half_enable          = hen_ff;
	assign address_bit_zero          = a0_ff;
	assign bus_tstate                = ts_ff;
endmodule : hes_pin
`default_nettype wire

// >>> hw/hes_pkg.sv
// Constants and types for the high-half enable / status pin block
package hes_pkg;
	// Bus T-state encoding as seen by this block
	typedef enum logic [2:0] {
		TS_IDLE,
		TS_T1,
		TS_T2,
		TS_T3,
		TS_T4
	} tstate_t;
	// Transfer kinds requested by the bus unit
	typedef enum logic [1:0] {
		XF_READ,
		XF_WRITE,
		XF_INTA
	} xfer_t;
	// Reset values of the pin flip-flops
	localparam logic RST_PIN_OUT = 1'b1;
	localparam logic RST_PIN_OE  = 1'b0;
	localparam logic RST_KEEP    = 1'b1;
	// Width of a transfer size request: 1 = byte, 2 = word
	localparam logic [1:0] SIZE_BYTE = 2'h1;
	localparam logic [1:0] SIZE_WORD = 2'h2;
	// Number of T-states in a bus cycle without wait states
	localparam logic [2:0] T_LAST = 3'h4;
endpackage : hes_pkg

// >>> tb/bus_high_half_enable_status_bench.sv
// Pin bench
`timescale 1ns/100ps
`default_nettype none
module bus_high_half_enable_status_bench;
	import hes_pkg::*;
	logic clk = 0, reset = 1, ce = 1, cycle_start = 0, addr_lsb = 0, inta_first = 0;
	logic wait_req = 0, hold_ack = 0, status_bit_seven = 0, upper_sel, lower_sel;
	logic [1:0] cycle_kind = 0, cycle_size = 1;
	logic high_enable_status_pin_o, high_enable_status_pin_oe;
	logic address_bit_zero, high_half_enable;
	logic [2:0] bus_tstate;
	int n_mismatch = 0, n_compared = 0, n_cyc = 0;
	hes_pin u_dut (.*);
	hes_periph u_far (.*);
	initial forever #50 clk = ~clk;
	// Hang guard
	always @(posedge clk) if (++n_cyc == 3000) begin
		n_mismatch++;
		finish_test();
	end
	task automatic chk(string n, logic e, logic g);
		n_compared++;
		if (g !== e) begin
			n_mismatch++;
			$display("FAIL %s exp %b got %b", n, e, g);
		end
	endtask
	// One cycle; next may start back to back
	task automatic cyc(logic [1:0] k, s, logic l, f, e, a);
		@(posedge clk);
		cycle_start <= 1;
		cycle_kind <= k;
		cycle_size <= s;
		addr_lsb <= l;
		inta_first <= f;
		status_bit_seven <= !e;
		@(posedge clk);
		cycle_start <= 0;
		#1 chk("enable", e, high_half_enable);
		chk("a0", a, address_bit_zero);
		chk("pin", e, high_enable_status_pin_o);
		chk("lane", !e, upper_sel);
		chk("lower", !a, lower_sel);
		@(posedge clk);
		#1;
		if (k != XF_INTA) chk("status", !e, high_enable_status_pin_o);
		else chk("float", 0, high_enable_status_pin_oe);
		// Next call raises the start in T4, so it is taken back to back
		@(posedge clk);
	endtask
	task automatic t_lanes;
		cyc(XF_READ, SIZE_WORD, 1, 0, 0, 0);
		cyc(XF_WRITE, SIZE_BYTE, 1, 0, 0, 1);
		cyc(XF_READ, SIZE_BYTE, 0, 0, 1, 0);
		$display("lanes done");
	endtask
	task automatic t_ack;
		cyc(XF_INTA, SIZE_BYTE, 1, 1, 0, 1);
		cyc(XF_INTA, SIZE_BYTE, 0, 0, 1, 0);
		$display("ack done");
	endtask
	task automatic t_hold;
		@(posedge clk);
		hold_ack <= 1;
		cycle_start <= 1;
		cycle_kind <= XF_READ;
		cycle_size <= SIZE_WORD;
		@(posedge clk);
		cycle_start <= 0;
		#1 chk("oe", 0, high_enable_status_pin_oe);
		chk("keep", 1, high_enable_status_pin_o);
		repeat (4) @(posedge clk);
		hold_ack <= 0;
		$display("hold done");
	endtask
	task automatic finish_test;
		$display("compared %0d mismatched %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	initial begin
		repeat (12) @(posedge clk);
		reset <= 0;
		t_lanes();
		t_ack();
		t_hold();
		finish_test();
	end
endmodule : bus_high_half_enable_status_bench
`default_nettype wire

// >>> tb/hes_periph.sv
// Far-side lane decode
`timescale 1ns/100ps
`default_nettype none
module hes_periph (
	input  wire logic high_half_enable, // Active low
	input  wire logic address_bit_zero, // Address bit 0
	output logic      upper_sel,        // Upper lane
	output logic      lower_sel         // Lower lane
);
	assign upper_sel = !high_half_enable;
	assign lower_sel = !address_bit_zero;
endmodule : hes_periph
`default_nettype wire

// >>> tb/hes_pin_props.sv
// Pin checker
`timescale 1ns/100ps
`default_nettype none
module hes_pin_props
	import hes_pkg::*;
(
	input wire logic clk, reset, ce, cycle_start, addr_lsb, inta_first,
	input wire logic hold_ack, status_bit_seven, high_half_enable,
	input wire logic [1:0] cycle_kind, cycle_size,
	input wire logic high_enable_status_pin_o, high_enable_status_pin_oe,
	input wire logic address_bit_zero,
	input wire logic [2:0] bus_tstate
);
	// Taken only in idle or T4
	wire logic g = ce && cycle_start && bus_tstate inside {TS_IDLE, TS_T4};
	wire logic o = high_enable_status_pin_o;
	wire logic oe = high_enable_status_pin_oe;
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	t1_drive_a: assert property (bus_tstate == TS_T1 && !$past(hold_ack) |-> oe && o == high_half_enable)
		else $error("T1 drive");
	upper_low_a: assert property (g && cycle_kind != XF_INTA |=>
		high_half_enable == ($past(cycle_size) == SIZE_BYTE && !$past(addr_lsb))) else $error("enable");
	lane_code_a: assert property (g |=>
		address_bit_zero == ($past(cycle_size) == SIZE_BYTE && $past(addr_lsb))) else $error("a0");
	first_ack_a: assert property (g && cycle_kind == XF_INTA && inta_first |=> !high_half_enable)
		else $error("ack");
	status_out_a: assert property (oe && bus_tstate > TS_T1 |-> o == $past(status_bit_seven))
		else $error("status");
	hold_float_a: assert property ($past(hold_ack) |-> !oe) else $error("hold");
	keep_level_a: assert property (!oe && !$past(oe) |-> $stable(o)) else $error("keep");
	cover property (g && cycle_kind == XF_INTA);
	cover property (g && cycle_size == SIZE_WORD);
	cover property (hold_ack && !oe);
endmodule : hes_pin_props
bind hes_pin hes_pin_props u_props (.*);
`default_nettype wire
